// >>> shared/cwd_pkg.sv
package cwd_pkg;

    // ----------------------------------------------------------------
    // configuration word layout
    // ----------------------------------------------------------------
    localparam int unsigned CFG_WIDTH       = 12;      // word width
    localparam int unsigned PROT_MSB        = 11;      // protect field top
    localparam int unsigned PROT_LSB        = 3;       // protect field bottom
    localparam int unsigned PROT_BIT_OLD    = 3;       // single protect bit, older parts
    localparam int unsigned WDOG_EN_BIT     = 2;       // watchdog enable bit
    localparam int unsigned OSC_MSB         = 1;       // oscillator field top
    localparam int unsigned OSC_LSB         = 0;       // oscillator field bottom

    // ----------------------------------------------------------------
    // apb register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_CFG_WORD   = 12'h000; // raw word, write while unlocked
    localparam logic [11:0] ADDR_CTRL       = 12'h004; // bit0 lock, bit1 variant, bit2 factory
    localparam logic [11:0] ADDR_STATUS     = 12'h008; // decoded settings
    localparam logic [11:0] ADDR_FACT_OSC   = 12'h00c; // factory oscillator value

    // ----------------------------------------------------------------
    // reset values and load settle count
    // ----------------------------------------------------------------
    localparam logic [11:0] CFG_RESET       = 12'hfff; // erased word: unprotected, r-c, watchdog on
    localparam logic [2:0]  CTRL_RESET      = 3'h0;    // unlocked, multi-bit, user osc
    localparam logic [1:0]  FACT_OSC_RESET  = 2'h3;    // resistor-capacitor by default
    localparam int unsigned LOAD_CYCLES     = 2;       // settle count that ends load; load lasts 3 cycles after lock

    // literal names differ from the one-hot mode ports, which import the package
    typedef enum logic [1:0] {
        OSC_LOW_POWER,
        OSC_STANDARD,
        OSC_HIGH_SPEED,
        OSC_RES_CAP
    } cwd_osc_t;

    typedef enum {
        CWD_PROGRAM,
        CWD_LOAD,
        CWD_RUN
    } cwd_state_t;

endpackage

// >>> verilog/cwd_word_store.sv
`timescale 1ns/1ps
// holds the raw word written by the programmer; read data registered
module cwd_word_store #(
    parameter int unsigned WIDTH = 12
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic      [WIDTH-1:0] rd_data
);
    import cwd_pkg::*;

    // elaboration-time refusal of a width the decoder cannot serve
    if (WIDTH != CFG_WIDTH) begin : g_bad_width
        $error("word store width must be the config width");
    end

    logic [WIDTH-1:0] word_q;   // stored word

    // ----------------------------------------------------------------
    // storage and registered read
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_q  <= CFG_RESET;
            rd_data <= CFG_RESET;
        end else begin
            if (wr_en) begin
                word_q <= wr_data;
            end
            rd_data <= word_q;
        end
    end
endmodule

// >>> verilog/cwd_field_decode.sv
`timescale 1ns/1ps
// splits the configuration word into its settings
module cwd_field_decode (
    input  wire logic [11:0] word,
    input  wire logic        older_variant,
    input  wire logic        factory_part,
    input  wire logic [1:0]  factory_osc,
    output logic             code_protect_n,
    output logic             watchdog_enable_cfg,
    output logic [1:0]       osc_type_select
);
    import cwd_pkg::*;

    // multi-bit parts: protection off only when every protect bit is 1; older parts use bit 3 alone
    wire all_prot_n = &word[PROT_MSB:PROT_LSB];
    wire old_prot_n = word[PROT_BIT_OLD];

    assign code_protect_n      = older_variant ? old_prot_n : all_prot_n;
    assign watchdog_enable_cfg = word[WDOG_EN_BIT];
    // factory parts ignore the user's field entirely
    assign osc_type_select     = factory_part ? factory_osc
                                              : word[OSC_MSB:OSC_LSB];
endmodule

// >>> verilog/cwd_top.sv
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module cwd_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             code_protect_n,
    output logic             watchdog_enable_cfg,
    output cwd_pkg::cwd_osc_t osc_type_select,
    output logic             low_power_crystal_mode,
    output logic             standard_crystal_mode,
    output logic             high_speed_crystal_mode,
    output logic             resistor_capacitor_osc_mode,
    output logic             config_valid
);
    import cwd_pkg::*;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup_ph  = psel & ~penable;          // first cycle of a transfer
    wire acc_ph    = psel & penable;           // access, answered at once
    wire wr_acc    = acc_ph & pwrite;
    wire hit_word  = (paddr == ADDR_CFG_WORD);
    wire hit_ctrl  = (paddr == ADDR_CTRL);
    wire hit_stat  = (paddr == ADDR_STATUS);
    wire hit_fosc  = (paddr == ADDR_FACT_OSC);
    wire mapped    = hit_word | hit_ctrl | hit_stat | hit_fosc;

    cwd_state_t state_q;                       // programming / load / run
    cwd_state_t state_d;
    logic [2:0]  ctrl_q;                       // lock, older variant, factory
    logic [1:0]  fosc_q;                       // factory oscillator value
    logic [1:0]  cnt_q;                        // settle counter
    logic [11:0] word_rd;                      // stored word
    logic        locked;

    assign locked = (state_q != CWD_PROGRAM);

    // writes to the word and the variant straps are refused once locked,
    // so nothing the block decodes can move while running
    wire word_we = wr_acc & hit_word & ~locked;
    wire ctrl_we = wr_acc & hit_ctrl & ~locked;
    wire fosc_we = wr_acc & hit_fosc & ~locked;
    // refused request: unmapped, or a write while locked (status writes are ignored)
    wire err_cond = ~mapped | (pwrite & locked & ~hit_stat);

    // ----------------------------------------------------------------
    // word storage
    // ----------------------------------------------------------------
    cwd_word_store #(
        .WIDTH (CFG_WIDTH)
    ) cwd_word_store_i (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (word_we),
        .wr_data (pwdata[11:0]),
        .rd_data (word_rd)
    );

    // ----------------------------------------------------------------
    // decode of the stored word
    // ----------------------------------------------------------------
    logic       dec_prot_n;
    logic       dec_wdog;
    logic [1:0] dec_osc;

    cwd_field_decode cwd_field_decode_i (
        .word                (word_rd),
        .older_variant       (ctrl_q[1]),
        .factory_part        (ctrl_q[2]),
        .factory_osc         (fosc_q),
        .code_protect_n      (dec_prot_n),
        .watchdog_enable_cfg (dec_wdog),
        .osc_type_select     (dec_osc)
    );

    // ----------------------------------------------------------------
    // sequencing: program, then load settle, then run until reset
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            CWD_PROGRAM: begin
                if (wr_acc & hit_ctrl & pwdata[0]) begin
                    state_d = CWD_LOAD;        // lock requested
                end
            end
            CWD_LOAD: begin
                if (cnt_q == 2'(LOAD_CYCLES)) begin
                    state_d = CWD_RUN;
                end
            end
            CWD_RUN:  state_d = CWD_RUN;       // only reset leaves run
            default:  state_d = CWD_PROGRAM;
        endcase
    end

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CWD_PROGRAM;
            ctrl_q  <= CTRL_RESET;
            fosc_q  <= FACT_OSC_RESET;
            cnt_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            if (ctrl_we) begin
                ctrl_q <= pwdata[2:0];
            end
            if (fosc_we) begin
                fosc_q <= pwdata[1:0];
            end
            // count only while loading; stored word needs a cycle to reach the decoder
            cnt_q <= (state_q == CWD_LOAD) ? cnt_q + 2'h1 : 2'h0;
        end
    end

    // ----------------------------------------------------------------
    // decoded outputs, captured once on entering run and then held
    // ----------------------------------------------------------------
    wire capture = (state_q == CWD_LOAD) & (state_d == CWD_RUN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_protect_n              <= 1'b1;
            watchdog_enable_cfg         <= 1'b0;
            osc_type_select             <= OSC_RES_CAP;
            low_power_crystal_mode      <= 1'b0;
            standard_crystal_mode       <= 1'b0;
            high_speed_crystal_mode     <= 1'b0;
            resistor_capacitor_osc_mode <= 1'b0;
            config_valid                <= 1'b0;
        end else if (capture) begin
            code_protect_n              <= dec_prot_n;
            watchdog_enable_cfg         <= dec_wdog;
            osc_type_select             <= cwd_osc_t'(dec_osc);
            low_power_crystal_mode      <= (dec_osc == 2'h0);
            standard_crystal_mode       <= (dec_osc == 2'h1);
            high_speed_crystal_mode     <= (dec_osc == 2'h2);
            resistor_capacitor_osc_mode <= (dec_osc == 2'h3);
            config_valid                <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // apb read data and answer; zero wait states
    // ----------------------------------------------------------------
    wire [31:0] stat_word = {24'h0, 1'b0, config_valid, 1'b0,
                             code_protect_n, watchdog_enable_cfg, osc_type_select,
                             locked};
    wire [31:0] rd_mux = hit_word ? {20'h0, word_rd}
                       : hit_ctrl ? {29'h0, ctrl_q[2:1], locked}
                       : hit_stat ? stat_word
                       : hit_fosc ? {30'h0, fosc_q}
                       : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // answer registered from setup, so ready is high in the access cycle
            pready  <= setup_ph;
            pslverr <= setup_ph & err_cond;
            prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h0;
        end
    end

endmodule

// >>> tb/cwd_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the configuration word decoder
// ------------------------------------------------------------
module cwd_checker (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              code_protect_n,
    input wire logic              watchdog_enable_cfg,
    input wire cwd_pkg::cwd_osc_t osc_type_select,
    input wire logic              low_power_crystal_mode,
    input wire logic              standard_crystal_mode,
    input wire logic              high_speed_crystal_mode,
    input wire logic              resistor_capacitor_osc_mode,
    input wire logic              config_valid
);
    import cwd_pkg::*;
    // single domain, so clock and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [3:0] mode_vec = {resistor_capacitor_osc_mode, high_speed_crystal_mode,
                           standard_crystal_mode, low_power_crystal_mode};
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
    property p_onehot; config_valid |-> mode_vec == (4'h1 << osc_type_select); endproperty
    a_onehot: assert property (p_onehot) else $error("mode flags disagree");
    // once captured, settings must never move again
    property p_hold;
        config_valid |=> config_valid && $stable(code_protect_n)
            && $stable(watchdog_enable_cfg) && $stable(osc_type_select);
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed after capture");
    c_valid: cover property ($rose(config_valid));
    c_err: cover property (pslverr);
    c_rc: cover property (config_valid && resistor_capacitor_osc_mode);
endmodule

bind cwd_top cwd_checker cwd_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .code_protect_n(code_protect_n),
    .watchdog_enable_cfg(watchdog_enable_cfg), .osc_type_select(osc_type_select),
    .low_power_crystal_mode(low_power_crystal_mode),
    .standard_crystal_mode(standard_crystal_mode),
    .high_speed_crystal_mode(high_speed_crystal_mode),
    .resistor_capacitor_osc_mode(resistor_capacitor_osc_mode), .config_valid(config_valid));

// >>> tb/cwd_prog_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// programmer model: apb master writing the configuration word
// ------------------------------------------------------------
module cwd_prog_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end
    // one transfer; no latency assumed, the caller's timeout ends a hang
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;   // released bus shows no stale value
        pwdata <= ~d;
    endtask
endmodule

// >>> tb/config_word_decoder_test.sv
`timescale 1ns/1ps
module config_word_decoder_test;
    import cwd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire psel, penable, pwrite, pready, pslverr, prot_n, wdog, lowp, stdx, hisp, rescap, valid;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    cwd_osc_t osc;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #25 pclk = ~pclk;
    cwd_top cwd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .code_protect_n(prot_n), .watchdog_enable_cfg(wdog),
        .osc_type_select(osc), .low_power_crystal_mode(lowp), .standard_crystal_mode(stdx),
        .high_speed_crystal_mode(hisp), .resistor_capacitor_osc_mode(rescap),
        .config_valid(valid));
    cwd_prog_model cwd_prog_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic print_verdict;
        $display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            print_verdict;
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic ee);
        logic [31:0] r;
        logic e;
        cwd_prog_model_i.xfer(w, a, d, r, e);
        check({r[30:0], e}, {ed[30:0], ee});
    endtask
    // reset, with the reset-time outputs looked at before release
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check({prot_n, wdog, osc, lowp, stdx, hisp, rescap, valid}, 9'h160);
        @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic lock(input logic [11:0] word, input logic [2:0] ctrl);
        acc(1'b1, ADDR_CFG_WORD, {20'h0, word}, 32'h0, 1'b0);
        acc(1'b1, ADDR_CTRL, {29'h0, ctrl}, 32'h0, 1'b0);
        for (int n = 0; n < 8 && valid !== 1'b1; n++) @(negedge pclk);
    endtask
    task automatic expect_out(input logic ecp, input logic ewd, input logic [1:0] eo);
        check({valid, prot_n, wdog, osc}, {1'b1, ecp, ewd, eo});
        check({rescap, hisp, stdx, lowp}, 4'h1 << eo);
    endtask
    task automatic t_multi;
        logic [1:0] c;
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            do_reset;
            lock({(c[0] ? 9'h0ff : 9'h1ff), c[1], c}, 3'h1);
            expect_out(~c[0], c[1], c);
        end
        acc(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    endtask
    task automatic t_older;
        do_reset;
        lock(12'h00b, 3'h3);
        expect_out(1'b1, 1'b0, 2'h3);
    endtask
    task automatic t_factory;
        do_reset;
        acc(1'b1, ADDR_FACT_OSC, 32'h1, 32'h0, 1'b0);
        lock(12'hfff, 3'h5);
        expect_out(1'b1, 1'b1, 2'h1);
        acc(1'b1, ADDR_CFG_WORD, 32'h0, 32'h0, 1'b1);
        acc(1'b1, ADDR_FACT_OSC, 32'h2, 32'h0, 1'b1);
        acc(1'b0, ADDR_STATUS, 32'h0, 32'h5b, 1'b0);
        expect_out(1'b1, 1'b1, 2'h1);
    endtask
    initial begin
        t_multi;
        t_older;
        t_factory;
        print_verdict;
    end
endmodule
